// file: core/dsc_status_control.sv
// Purpose: Bits 7 to 19 of debug_status_control: sticky flags, debug controls, security status.
// Assumes: All inputs synchronous to clock; read and write strobes are one-cycle pulses.
// Notes: Every output is registered, so effects appear one cycle after an input changes and two cycles after a register write.
// Summary of operation
// - Undefined exception on a debug-state instruction sets sticky bit 8.
// - Newest version: sticky bit 8 clears only through run-control bit 2.
// - Sticky bit 8 holds unchanged outside debug state.
// - Intermediate version: bit 8 reads zero outside debug, clears on external read.
// - Newest version: bit 9 reads zero and ignores writes.
// - Force-ack bit 10 drives ack, trigger and cpu-done outputs high.
// - Inhibit bit 11 blocks normal and fast interrupt inputs.
// - Inhibit ignored whenever debug-mode enables read as zero.
// - Bit 12 makes user-mode comms register accesses undefined.
// - Bit 13 enables instruction execution; absent mechanism reads zero.
// - Bit 14 enables halting mode, masked and read zero while invasive enable low.
// - Bit 15 enables monitor mode, masked and read zero while invasive enable low.
// - Halting enabled forces monitor mode off.
// - Save path captures stored debug-mode enables, not masked ones.
// - Bit 16 reads inverse of secure invasive enable, zero without security.
// - Bit 17 reads inverse of secure non-invasive enable, zero without security.
// - Bit 18 reads one only with world bit set outside monitor mode.
// - Bit 19 sets automatically on debug entry and is read-only.
// - Bit 19 clears when debug state is left.
// - Imprecise abort while discarding sets sticky bit 7 and is dropped.
`timescale 1ns/1ps

module dsc_status_control #(
  parameter dsc_pkg::dsc_version_t VERSION = dsc_pkg::DSC_V7,
  parameter bit SECURITY_EXT = 1'h1,
  parameter bit EXEC_MECHANISM = 1'h1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Register access to debug_status_control.
  input wire logic regWrite,
  input wire logic [31:0] regWriteData,
  input wire logic extRead,
  input wire logic cpRead,
  output logic [31:0] readData,
  // Write to debug_run_control.
  input wire logic runCtrlWrite,
  input wire logic [31:0] runCtrlData,
  // Processor state and events.
  input wire dsc_pkg::dsc_core_t core,
  input wire dsc_pkg::dsc_auth_t auth,
  input wire logic undefInDebug,
  input wire logic impreciseAbort,
  output logic abortTaken,
  // Debug handshake from the core and forced outputs.
  input wire logic coreDebugAck,
  input wire logic coreTrigger,
  input wire logic coreCpuDone,
  output logic debugAckOut,
  output logic debugTriggerOut,
  output logic cpuDoneOut,
  // Interrupt inputs and gated outputs.
  input wire logic irqIn,
  input wire logic fastIrqIn,
  output logic irqOut,
  output logic fastIrqOut,
  // Coprocessor access check.
  input wire logic cpAccess,
  input wire logic cpUserMode,
  input wire logic cpCommsTarget,
  output logic cpAccessDone,
  output logic cpAccessUndef,
  // Effective mode enables and saved state.
  output logic haltingEnabled,
  output logic monitorEnabled,
  output logic execEnabled,
  output logic [1:0] saveModeBits
);
  import dsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stored control bits.

  logic forceAck;
  logic irqInhibit;
  logic userCommsOff;
  logic execEnable;
  logic haltStored;
  logic monitorStored;
  logic discardAbort;
  logic prevInDebug;
  logic stickyUndef;
  logic stickyImprecise;
  logic haltView;
  logic monitorView;
  logic inhibitActive;
  logic stickyClear;

  // reset to zero
  // Software writes the control field; reset leaves debug off, interrupts on.
  always_ff @(posedge clock) begin
    if (reset) begin
      forceAck <= DSC_RESET_CTRL;
      irqInhibit <= DSC_RESET_CTRL;
      userCommsOff <= DSC_RESET_CTRL;
      execEnable <= DSC_RESET_CTRL;
      haltStored <= DSC_RESET_CTRL;
      monitorStored <= DSC_RESET_CTRL;
    end else if (regWrite) begin
      forceAck <= regWriteData[DSC_BIT_FORCE_ACK];
      irqInhibit <= regWriteData[DSC_BIT_IRQ_INHIBIT];
      userCommsOff <= regWriteData[DSC_BIT_USER_COMMS_OFF];
      execEnable <= EXEC_MECHANISM & regWriteData[DSC_BIT_EXEC_ENABLE];
      haltStored <= regWriteData[DSC_BIT_HALT_ENABLE];
      monitorStored <= regWriteData[DSC_BIT_MONITOR_ENABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Masked mode enables.

  assign haltView = haltStored & auth.invasiveDebugEnableIn;
  assign monitorView = monitorStored & auth.invasiveDebugEnableIn;
  assign inhibitActive = irqInhibit & (haltView | monitorView);

  ////////////////////////////////////////////////////////////////////////////
  // Discard of imprecise aborts.

  // clear on exit
  // The bit follows debug entry and exit only; register writes never reach it.
  always_ff @(posedge clock) begin
    if (reset) begin
      discardAbort <= 1'h0;
      prevInDebug <= 1'h0;
    end else begin
      prevInDebug <= core.inDebugState;
      if (core.inDebugState && !prevInDebug) begin
        discardAbort <= 1'h1;
      end else if (!core.inDebugState) begin
        discardAbort <= 1'h0;
      end
    end
  end

  // abort dropped
  // An abort is passed on only while discarding is off.
  always_ff @(posedge clock) begin
    if (reset) begin
      abortTaken <= 1'h0;
    end else begin
      abortTaken <= impreciseAbort & ~discardAbort;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags.

  // read clears older
  // Clears act only in debug state, so the flags stand still outside it.
  assign stickyClear = core.inDebugState &
    ((VERSION == DSC_V7) ? (runCtrlWrite & runCtrlData[DSC_RUNCTRL_CLEAR_STICKY])
                         : extRead);

  dsc_sticky_flag undefFlag (
    .clock(clock),
    .reset(reset),
    .setEvent(undefInDebug & core.inDebugState),
    .clearEvent(stickyClear),
    .flag(stickyUndef)
  );

  dsc_sticky_flag impreciseFlag (
    .clock(clock),
    .reset(reset),
    .setEvent(impreciseAbort & discardAbort),
    .clearEvent(stickyClear),
    .flag(stickyImprecise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read view.

  // Builds the value software sees; used by both read paths.
  function automatic logic [31:0] readView();
    logic [31:0] view;
    view = DSC_RESET_READ;
    view[DSC_BIT_STICKY_UNDEF] = stickyUndef &
      ((VERSION == DSC_V7) | core.inDebugState);
    view[DSC_BIT_STICKY_IMPRECISE] = stickyImprecise &
      ((VERSION == DSC_V7) | core.inDebugState);
    view[DSC_BIT_NO_POWERDOWN] = 1'h0;
    view[DSC_BIT_FORCE_ACK] = forceAck;
    view[DSC_BIT_IRQ_INHIBIT] = irqInhibit;
    view[DSC_BIT_USER_COMMS_OFF] = userCommsOff;
    view[DSC_BIT_EXEC_ENABLE] = execEnable;
    view[DSC_BIT_HALT_ENABLE] = haltView;
    view[DSC_BIT_MONITOR_ENABLE] = monitorView;
    view[DSC_BIT_SECURE_INV_DIS] = SECURITY_EXT & ~auth.secureInvasiveEnableIn;
    view[DSC_BIT_SECURE_NONINV_DIS] = SECURITY_EXT & ~auth.secureNoninvasiveEnableIn;
    view[DSC_BIT_NONSECURE] = SECURITY_EXT & core.securityConfigWorld & ~core.monitorMode;
    view[DSC_BIT_DISCARD_ABORT] = discardAbort;
    return view;
  endfunction

  // Read data is captured on either read strobe and holds until the next.
  always_ff @(posedge clock) begin
    if (reset) begin
      readData <= DSC_RESET_READ;
    end else if (extRead || cpRead) begin
      readData <= readView();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forced handshake outputs.

  always_ff @(posedge clock) begin
    if (reset) begin
      debugAckOut <= 1'h0;
      debugTriggerOut <= 1'h0;
      cpuDoneOut <= 1'h0;
    end else begin
      debugAckOut <= coreDebugAck | forceAck;
      debugTriggerOut <= coreTrigger | forceAck;
      cpuDoneOut <= coreCpuDone | forceAck;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt gating.

  always_ff @(posedge clock) begin
    if (reset) begin
      irqOut <= 1'h0;
      fastIrqOut <= 1'h0;
    end else begin
      irqOut <= irqIn & ~inhibitActive;
      fastIrqOut <= fastIrqIn & ~inhibitActive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coprocessor access check.

  // user access undefined
  // Each access answers once: done, or undefined for a user-mode comms access while user comms are off.
  always_ff @(posedge clock) begin
    if (reset) begin
      cpAccessDone <= 1'h0;
      cpAccessUndef <= 1'h0;
    end else begin
      cpAccessUndef <= cpAccess & cpUserMode & cpCommsTarget & userCommsOff;
      cpAccessDone <= cpAccess & ~(cpUserMode & cpCommsTarget & userCommsOff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective modes and save path.

  always_ff @(posedge clock) begin
    if (reset) begin
      haltingEnabled <= 1'h0;
      monitorEnabled <= 1'h0;
      execEnabled <= 1'h0;
      saveModeBits <= 2'h0;
    end else begin
      haltingEnabled <= haltView;
      monitorEnabled <= monitorView & ~haltView;
      // debugger keeps bit 13 clear outside debug; gated defensively.
      execEnabled <= execEnable & core.inDebugState;
      saveModeBits <= {monitorStored, haltStored};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking dscClk @(posedge clock);
  endclocking
  default disable iff (reset);

  chk_undef_sets: assert property (
    undefInDebug && core.inDebugState |=> stickyUndef)
    else $error("sticky undefined flag not set");

  chk_undef_clear_src: assert property (
    (VERSION == DSC_V7) && $fell(stickyUndef)
    |-> $past(runCtrlWrite && runCtrlData[DSC_RUNCTRL_CLEAR_STICKY]))
    else $error("sticky undefined flag cleared without run-control write");

  chk_undef_holds: assert property (
    !core.inDebugState |=> stickyUndef == $past(stickyUndef))
    else $error("sticky undefined flag changed outside debug state");

  chk_bit9_zero: assert property (
    extRead |=> !readData[DSC_BIT_NO_POWERDOWN])
    else $error("reserved bit 9 read nonzero");

  chk_force_ack: assert property (
    regWrite && regWriteData[DSC_BIT_FORCE_ACK]
    |=> ##1 debugAckOut && debugTriggerOut && cpuDoneOut)
    else $error("forced acknowledge outputs not high");

  chk_irq_blocked: assert property (
    inhibitActive && (irqIn || fastIrqIn) |=> !irqOut && !fastIrqOut)
    else $error("interrupt passed while inhibited");

  chk_irq_passes: assert property (
    !auth.invasiveDebugEnableIn && irqIn |=> irqOut)
    else $error("interrupt blocked while debug modes read zero");

  chk_user_undef: assert property (
    cpAccess && cpUserMode && cpCommsTarget && userCommsOff
    |=> cpAccessUndef && !cpAccessDone)
    else $error("user comms access not made undefined");

  chk_mode_mask: assert property (
    (extRead || cpRead) && !auth.invasiveDebugEnableIn
    |=> !readData[DSC_BIT_HALT_ENABLE] && !readData[DSC_BIT_MONITOR_ENABLE])
    else $error("mode enables visible while invasive debug disabled");

  chk_monitor_off: assert property (
    haltingEnabled |-> !monitorEnabled)
    else $error("monitor mode enabled together with halting mode");

  chk_save_stored: assert property (
    regWrite |=> ##1 saveModeBits ==
      $past({regWriteData[DSC_BIT_MONITOR_ENABLE], regWriteData[DSC_BIT_HALT_ENABLE]}, 2))
    else $error("save path lost stored mode bits");

  chk_discard_exit: assert property (
    $fell(core.inDebugState) |=> !discardAbort)
    else $error("discard bit not cleared on debug exit");

  chk_abort_drop: assert property (
    impreciseAbort && discardAbort |=> stickyImprecise && !abortTaken)
    else $error("discarded abort not flagged or not dropped");

  cov_undef_in_debug: cover property (undefInDebug && core.inDebugState ##1 stickyUndef);
  cov_abort_discard: cover property (impreciseAbort && discardAbort);
  cov_inhibit_irq: cover property (inhibitActive && irqIn);
  cov_user_undef: cover property (cpAccessUndef);

endmodule // dsc_status_control

// file: core/dsc_pkg.sv
// Purpose: Shared constants and types for the debug status and control block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Bit positions refer to the 32-bit debug_status_control register, apart from the sticky-clear request in debug_run_control.
package dsc_pkg;

  // Architecture version of the debug logic.
  typedef enum logic {DSC_V61, DSC_V7} dsc_version_t;

  // Field positions in debug_status_control.
  localparam int DSC_BIT_STICKY_IMPRECISE = 7;
  localparam int DSC_BIT_STICKY_UNDEF = 8;
  localparam int DSC_BIT_NO_POWERDOWN = 9;
  localparam int DSC_BIT_FORCE_ACK = 10;
  localparam int DSC_BIT_IRQ_INHIBIT = 11;
  localparam int DSC_BIT_USER_COMMS_OFF = 12;
  localparam int DSC_BIT_EXEC_ENABLE = 13;
  localparam int DSC_BIT_HALT_ENABLE = 14;
  localparam int DSC_BIT_MONITOR_ENABLE = 15;
  localparam int DSC_BIT_SECURE_INV_DIS = 16;
  localparam int DSC_BIT_SECURE_NONINV_DIS = 17;
  localparam int DSC_BIT_NONSECURE = 18;
  localparam int DSC_BIT_DISCARD_ABORT = 19;

  // Field position of the sticky-clear request in debug_run_control.
  localparam int DSC_RUNCTRL_CLEAR_STICKY = 2;

  // Reset values of the stored control bits and of the read data.
  localparam logic DSC_RESET_CTRL = 1'h0;
  localparam logic [31:0] DSC_RESET_READ = 32'h0000_0000;

  // Processor state seen by the block.
  typedef struct packed {
    logic inDebugState;
    logic monitorMode;
    logic securityConfigWorld;
  } dsc_core_t;

  // Authentication inputs.
  typedef struct packed {
    logic invasiveDebugEnableIn;
    logic secureInvasiveEnableIn;
    logic secureNoninvasiveEnableIn;
  } dsc_auth_t;

endpackage

// file: core/dsc_sticky_flag.sv
// Purpose: One sticky flag that hardware sets and a clear request resets.
// Assumes: Synchronous active-high reset.
// Notes: A set in the same cycle as a clear wins, so no event is lost.
`timescale 1ns/1ps

module dsc_sticky_flag (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Set and clear requests.
  input wire logic setEvent,
  input wire logic clearEvent,
  // Flag state.
  output logic flag
);

  // Set has priority over clear.
  always_ff @(posedge clock) begin
    if (reset) begin
      flag <= 1'h0;
    end else if (setEvent) begin
      flag <= 1'h1;
    end else if (clearEvent) begin
      flag <= 1'h0;
    end
  end

endmodule // dsc_sticky_flag

// file: testbench/dsc_debugger_model.sv
// Purpose: Behavioural external debugger that writes and reads debug_status_control.
// Assumes: Requests change just after a rising clock edge and last one cycle.
// Notes: Released data lines show the inverse of their last value.
`timescale 1ns/1ps

module dsc_debugger_model (
  // Clock and processor state.
  input wire logic clock,
  input wire logic inDebugState,
  // Register and run-control requests.
  output logic regWrite,
  output logic [31:0] regWriteData,
  output logic extRead,
  output logic runCtrlWrite,
  output logic [31:0] runCtrlData,
  // Read answer.
  input wire logic [31:0] readData
);
  import dsc_pkg::*;

  // Idle requests at time zero.
  initial begin
    regWrite = 1'h0;
    regWriteData = 32'h0;
    extRead = 1'h0;
    runCtrlWrite = 1'h0;
    runCtrlData = 32'h0;
  end

  // exec enable masked
  // Execution enable is never set outside debug state.
  task automatic write_reg(input logic [31:0] d);
    @(posedge clock);
    regWrite <= 1'h1;
    regWriteData <= inDebugState ? d : (d & ~(32'h1 << DSC_BIT_EXEC_ENABLE));
    @(posedge clock);
    regWrite <= 1'h0;
    regWriteData <= ~regWriteData;
  endtask

  // Read with the external side effect; data is taken one cycle after the strobe.
  task automatic read_ext(output logic [31:0] d);
    @(posedge clock);
    extRead <= 1'h1;
    @(posedge clock);
    extRead <= 1'h0;
    #1 d = readData;
  endtask

  // Request a sticky clear through debug_run_control.
  task automatic run_clear();
    @(posedge clock);
    runCtrlWrite <= 1'h1;
    runCtrlData <= 32'h1 << DSC_RUNCTRL_CLEAR_STICKY;
    @(posedge clock);
    runCtrlWrite <= 1'h0;
    runCtrlData <= ~runCtrlData;
  endtask
endmodule // dsc_debugger_model

// file: testbench/dsc_status_control_bench.sv
// Purpose: Self-checking bench for the debug status and control bits.
// Assumes: Newest version with all options, beside an older one with none, on shared inputs.
// Notes: Inputs change by non-blocking assignment on the rising edge.
`timescale 1ns/1ps

module dsc_status_control_bench;
  import dsc_pkg::*;

  logic clock, reset, cpRead, runCtrlWrite, regWrite, extRead;
  logic [31:0] regWriteData, runCtrlData, readData, d;
  dsc_core_t core;
  dsc_auth_t auth;
  logic undefInDebug, impreciseAbort, abortTaken, coreDebugAck, coreTrigger, coreCpuDone;
  logic debugAckOut, debugTriggerOut, cpuDoneOut, irqIn, fastIrqIn, irqOut, fastIrqOut;
  logic cpAccess, cpUserMode, cpCommsTarget, cpAccessDone, cpAccessUndef;
  logic haltingEnabled, monitorEnabled, execEnabled;
  logic [1:0] saveModeBits;
  logic [31:0] readOld;
  logic execOld;
  int n_fail = 0;
  int total_checks = 0;

  dsc_status_control uut (.clock(clock), .reset(reset), .regWrite(regWrite),
    .regWriteData(regWriteData), .extRead(extRead), .cpRead(cpRead), .readData(readData),
    .runCtrlWrite(runCtrlWrite), .runCtrlData(runCtrlData), .core(core), .auth(auth),
    .undefInDebug(undefInDebug), .impreciseAbort(impreciseAbort), .abortTaken(abortTaken),
    .coreDebugAck(coreDebugAck), .coreTrigger(coreTrigger), .coreCpuDone(coreCpuDone),
    .debugAckOut(debugAckOut), .debugTriggerOut(debugTriggerOut), .cpuDoneOut(cpuDoneOut),
    .irqIn(irqIn), .fastIrqIn(fastIrqIn), .irqOut(irqOut), .fastIrqOut(fastIrqOut),
    .cpAccess(cpAccess), .cpUserMode(cpUserMode), .cpCommsTarget(cpCommsTarget),
    .cpAccessDone(cpAccessDone), .cpAccessUndef(cpAccessUndef),
    .haltingEnabled(haltingEnabled), .monitorEnabled(monitorEnabled),
    .execEnabled(execEnabled), .saveModeBits(saveModeBits));

  // Older version without security or execution mechanism, fed the same stimulus.
  dsc_status_control #(.VERSION(DSC_V61), .SECURITY_EXT(1'h0),
    .EXEC_MECHANISM(1'h0)) uutOld (.clock(clock), .reset(reset), .regWrite(regWrite),
    .regWriteData(regWriteData), .extRead(extRead), .cpRead(cpRead), .readData(readOld),
    .runCtrlWrite(runCtrlWrite), .runCtrlData(runCtrlData), .core(core), .auth(auth),
    .undefInDebug(undefInDebug), .impreciseAbort(impreciseAbort), .abortTaken(),
    .coreDebugAck(coreDebugAck), .coreTrigger(coreTrigger), .coreCpuDone(coreCpuDone),
    .debugAckOut(), .debugTriggerOut(), .cpuDoneOut(),
    .irqIn(irqIn), .fastIrqIn(fastIrqIn), .irqOut(), .fastIrqOut(),
    .cpAccess(cpAccess), .cpUserMode(cpUserMode), .cpCommsTarget(cpCommsTarget),
    .cpAccessDone(), .cpAccessUndef(), .haltingEnabled(), .monitorEnabled(),
    .execEnabled(execOld), .saveModeBits());

  dsc_debugger_model dbg (.clock(clock), .inDebugState(core.inDebugState),
    .regWrite(regWrite), .regWriteData(regWriteData), .extRead(extRead),
    .runCtrlWrite(runCtrlWrite), .runCtrlData(runCtrlData), .readData(readData));

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 4 ns period.
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  // Compare one value and count the result.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Let a write reach the derived outputs.
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  // Coprocessor read, which has no side effect.
  task automatic cp_read(output logic [31:0] v);
    @(posedge clock);
    cpRead <= 1'h1;
    @(posedge clock);
    cpRead <= 1'h0;
    #1 v = readData;
  endtask

  // One-cycle pulse on an event input.
  task automatic pulse_undef();
    @(posedge clock);
    undefInDebug <= 1'h1;
    @(posedge clock);
    undefInDebug <= 1'h0;
  endtask

  task automatic pulse_abort(input logic expTaken);
    @(posedge clock);
    impreciseAbort <= 1'h1;
    @(posedge clock);
    impreciseAbort <= 1'h0;
    #1 chk({31'h0, abortTaken}, {31'h0, expTaken});
  endtask

  task automatic cp_access(input logic user, input logic target, input logic [1:0] exp);
    @(posedge clock);
    cpAccess <= 1'h1;
    cpUserMode <= user;
    cpCommsTarget <= target;
    @(posedge clock);
    cpAccess <= 1'h0;
    #1 chk({30'h0, cpAccessDone, cpAccessUndef}, {30'h0, exp});
  endtask

  task automatic set_debug(input logic v);
    @(posedge clock);
    core.inDebugState <= v;
    settle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_control();
    cp_read(d);
    chk(d, DSC_RESET_READ);
    dbg.write_reg(32'h0000_0400);
    settle();
    chk({29'h0, debugAckOut, debugTriggerOut, cpuDoneOut}, 32'h7);
    dbg.write_reg(32'h0000_4800);
    @(posedge clock);
    irqIn <= 1'h1;
    fastIrqIn <= 1'h1;
    settle();
    chk({29'h0, debugAckOut, irqOut, fastIrqOut}, 32'h0);
    @(posedge clock);
    {coreDebugAck, coreTrigger, coreCpuDone} <= 3'h5;
    settle();
    chk({29'h0, debugAckOut, debugTriggerOut, cpuDoneOut}, 32'h5);
    @(posedge clock);
    {coreDebugAck, coreTrigger, coreCpuDone} <= 3'h0;
    auth.invasiveDebugEnableIn <= 1'h0;
    settle();
    chk({30'h0, irqOut, fastIrqOut}, 32'h3);
    cp_read(d);
    chk({30'h0, d[15:14]}, 32'h0);
    chk({28'h0, haltingEnabled, monitorEnabled, saveModeBits}, 32'h1);
    @(posedge clock);
    auth.invasiveDebugEnableIn <= 1'h1;
    dbg.write_reg(32'h0000_0800);
    settle();
    chk({30'h0, irqOut, fastIrqOut}, 32'h3);
    dbg.write_reg(32'h0000_C000);
    settle();
    chk({28'h0, haltingEnabled, monitorEnabled, saveModeBits}, 32'hB);
    dbg.write_reg(32'h0000_8000);
    settle();
    chk({28'h0, haltingEnabled, monitorEnabled, saveModeBits}, 32'h6);
    cp_read(d);
    chk({30'h0, d[15:14]}, 32'h2);
    dbg.write_reg(32'h0000_1000);
    settle();
    cp_access(1'h1, 1'h1, 2'h1);
    cp_access(1'h0, 1'h1, 2'h2);
    cp_access(1'h1, 1'h0, 2'h2);
    dbg.write_reg(32'h0);
    settle();
    cp_access(1'h1, 1'h1, 2'h2);
    $display("control test done");
  endtask

  task automatic t_sticky();
    set_debug(1'h1);
    pulse_undef();
    dbg.write_reg(32'h0000_2200);
    settle();
    chk({31'h0, execEnabled}, 32'h1);
    chk({31'h0, execOld}, 32'h0);
    dbg.read_ext(d);
    chk({28'h0, d[19], d[13], d[9], d[8]}, 32'hD);
    chk({28'h0, readOld[19], readOld[13], readOld[9], readOld[8]}, 32'h9);
    dbg.read_ext(d);
    chk({30'h0, d[9], d[8]}, 32'h1);
    chk({31'h0, readOld[8]}, 32'h0);
    pulse_abort(1'h0);
    cp_read(d);
    chk({31'h0, d[7]}, 32'h1);
    pulse_undef();
    // exec enable cleared before leaving debug state.
    dbg.write_reg(32'h0);
    set_debug(1'h0);
    dbg.run_clear();
    cp_read(d);
    chk({30'h0, d[19], d[8]}, 32'h1);
    chk({31'h0, d[19]}, 32'h0);
    chk({30'h0, readOld[8], readOld[7]}, 32'h0);
    pulse_abort(1'h1);
    set_debug(1'h1);
    dbg.run_clear();
    dbg.read_ext(d);
    chk({30'h0, d[8], d[7]}, 32'h0);
    chk({30'h0, readOld[8], readOld[7]}, 32'h3);
    set_debug(1'h0);
    $display("sticky test done");
  endtask

  task automatic t_security();
    @(posedge clock);
    auth.secureInvasiveEnableIn <= 1'h0;
    auth.secureNoninvasiveEnableIn <= 1'h0;
    core.securityConfigWorld <= 1'h1;
    settle();
    cp_read(d);
    chk({29'h0, d[18:16]}, 32'h7);
    chk({29'h0, readOld[18:16]}, 32'h0);
    @(posedge clock);
    auth.secureInvasiveEnableIn <= 1'h1;
    auth.secureNoninvasiveEnableIn <= 1'h1;
    core.monitorMode <= 1'h1;
    settle();
    cp_read(d);
    chk({29'h0, d[18:16]}, 32'h0);
    $display("security test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Print counts and verdict, then stop.
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    end_sim();
  end

  // Main sequence.
  initial begin
    reset = 1'h1;
    cpRead = 1'h0;
    core = '0;
    auth = 3'h7;
    {undefInDebug, impreciseAbort, coreDebugAck, coreTrigger, coreCpuDone} = 5'h0;
    {irqIn, fastIrqIn, cpAccess, cpUserMode, cpCommsTarget} = 5'h0;
    repeat (6) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    t_control();
    t_sticky();
    t_security();
    end_sim();
  end
endmodule // dsc_status_control_bench
